// ---- chan_divider.v ----
`timescale 1ns/10ps
`include "chdiv_regs.vh"
module chan_divider (
   // Clock and reset.
   input  wire       CLOCK,
   input  wire       RST,
   // Settings and control.
   input  wire [7:0] counts,
   input  wire [7:0] control,
   input  wire       dcc_disable,
   input  wire       sync_pulse,
   input  wire       div_in,
   // Output.
   output wire       div_out
);
   localparam ST_PHASE = 2'b01;
   localparam ST_RUN   = 2'b10;
   reg [1:0] state_reg;
   reg [3:0] cnt_reg;
   reg       lvl_reg;
   reg       fall_reg;
   wire      bypass  = control[`BIT_BYPASS];
   wire      nosync  = control[`BIT_NOSYNC];
   wire      start_hi = control[`BIT_START];
   wire [3:0] lim = lvl_reg ? counts[3:0] : counts[7:4];
   wire      dcc_out;
   always @(posedge CLOCK) begin
      if (RST || bypass) begin
         state_reg <= ST_RUN;
         cnt_reg   <= 4'h0;
         lvl_reg   <= 1'b0;
      end else if (sync_pulse && !nosync) begin
         state_reg <= ST_PHASE;
         cnt_reg   <= 4'h0;
         lvl_reg   <= start_hi;
      end else begin
         case (state_reg)
            ST_PHASE: begin
               if (cnt_reg >= control[3:0]) begin
                  state_reg <= ST_RUN;
                  cnt_reg   <= 4'h0;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            ST_RUN: begin
               if (cnt_reg >= lim) begin
                  cnt_reg <= 4'h0;
                  lvl_reg <= ~lvl_reg;
               end else begin
                  cnt_reg <= cnt_reg + 4'h1;
               end
            end
            default: begin
               state_reg <= ST_RUN;
               cnt_reg   <= 4'h0;
            end
         endcase
      end
   end
   // Duty correction: with unequal halves the high phase starts half late.
   always @(negedge CLOCK) begin
      if (RST) begin
         fall_reg <= 1'b0;
      end else begin
         fall_reg <= lvl_reg;
      end
   end
   assign dcc_out = (!dcc_disable && (counts[3:0] != counts[7:4])) ?
                    (lvl_reg & fall_reg) : lvl_reg;
   assign div_out = bypass ? div_in :
                    nosync ? control[`BIT_FORCE] : dcc_out;
endmodule // chan_divider

// ---- chdiv_regs.vh ----
`ifndef CHDIV_REGS_VH
`define CHDIV_REGS_VH
`define IDX_DIV0_COUNTS  12'h190
`define IDX_DIV0_CONTROL 12'h191
`define IDX_DIV0_PATH    12'h192
`define IDX_DIV1_COUNTS  12'h193
`define IDX_DIV1_CONTROL 12'h194
`define IDX_PATH_SELECT  12'h1E1
`define RST_DIV0_COUNTS  8'h00
`define RST_DIV0_CONTROL 8'h80
`define RST_DIV0_PATH    8'h00
`define RST_DIV1_COUNTS  8'hBB
`define RST_DIV1_CONTROL 8'h00
`define RST_PATH_SELECT  8'h00
`define BIT_BYPASS       7
`define BIT_NOSYNC       6
`define BIT_FORCE        5
`define BIT_START        4
`define BIT_DIRECT       1
`define BIT_DCC_DISABLE  0
`define SEL_VCO          2'h2
`define SEL_CLK          2'h0
`endif

// ---- lvpecl_channel_divider.v ----
`timescale 1ns/10ps
`include "chdiv_regs.vh"
module lvpecl_channel_divider (
   // Clock and reset.
   input  wire        CLOCK,
   input  wire        RST,
   // APB slave.
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [13:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   // Clock sources and chip sync.
   input  wire        DIV_IN,
   input  wire        VCO_IN,
   input  wire        CLK_IN,
   input  wire        SYNC_N,
   // Outputs.
   output wire        FIRST_PAIR_POS_OUTPUT,
   output wire        FIRST_PAIR_NEG_OUTPUT,
   output wire        DIV1_OUT
);
   // Register storage.
   reg  [7:0]  div0_counts_reg;
   reg  [7:0]  div0_control_reg;
   reg  [7:0]  div0_path_reg;
   reg  [7:0]  div1_counts_reg;
   reg  [7:0]  div1_control_reg;
   reg  [7:0]  path_select_reg;

   // Next values of the registers.
   reg  [7:0]  div0_counts_next;
   reg  [7:0]  div0_control_next;
   reg  [7:0]  div0_path_next;
   reg  [7:0]  div1_counts_next;
   reg  [7:0]  div1_control_next;
   reg  [7:0]  path_select_next;

   // Read path and chip sync state.
   reg  [7:0]  rd_byte;
   reg  [31:0] rdata_next;
   reg         sync_d_reg;
   reg         pair_reg;

   // Bus decode.
   wire [11:0] idx;
   wire        setup_phase;
   wire        access_phase;
   wire        wr;
   wire        sel_div0_counts;
   wire        sel_div0_control;
   wire        sel_div0_path;
   wire        sel_div1_counts;
   wire        sel_div1_control;
   wire        sel_path_select;
   wire        hit;

   // Divider wiring.
   wire        sync_lvl;
   wire        sync_pulse;
   wire [15:0] div_counts;
   wire [15:0] div_control;
   wire [1:0]  div_dcc_disable;
   wire [1:0]  div_out;
   wire        div0_out;
   wire        dir_out;

   // Each register takes one word; the index is the word address.
   assign idx          = PADDR[13:2];
   assign setup_phase  = PSEL && !PENABLE;
   assign access_phase = PSEL && PENABLE;
   assign wr           = access_phase && PWRITE;

   assign sel_div0_counts  = (idx == `IDX_DIV0_COUNTS);
   assign sel_div0_control = (idx == `IDX_DIV0_CONTROL);
   assign sel_div0_path    = (idx == `IDX_DIV0_PATH);
   assign sel_div1_counts  = (idx == `IDX_DIV1_COUNTS);
   assign sel_div1_control = (idx == `IDX_DIV1_CONTROL);
   assign sel_path_select  = (idx == `IDX_PATH_SELECT);

   assign hit = sel_div0_counts || sel_div0_control || sel_div0_path ||
                sel_div1_counts || sel_div1_control || sel_path_select;

   // Zero-wait slave; an unmapped word answers with an error.
   assign PREADY  = 1'b1;
   assign PSLVERR = access_phase && !hit;

   // A write lands only at the edge that ends the access phase.
   always @* begin
      if (wr && sel_div0_counts) begin
         div0_counts_next = PWDATA[7:0];
      end else begin
         div0_counts_next = div0_counts_reg;
      end
   end

   always @* begin
      if (wr && sel_div0_control) begin
         div0_control_next = PWDATA[7:0];
      end else begin
         div0_control_next = div0_control_reg;
      end
   end

   // Only the direct and correction bits exist in the path register.
   always @* begin
      if (wr && sel_div0_path) begin
         div0_path_next = PWDATA[7:0] & 8'h03;
      end else begin
         div0_path_next = div0_path_reg;
      end
   end

   always @* begin
      if (wr && sel_div1_counts) begin
         div1_counts_next = PWDATA[7:0];
      end else begin
         div1_counts_next = div1_counts_reg;
      end
   end

   always @* begin
      if (wr && sel_div1_control) begin
         div1_control_next = PWDATA[7:0];
      end else begin
         div1_control_next = div1_control_reg;
      end
   end

   always @* begin
      if (wr && sel_path_select) begin
         path_select_next = PWDATA[7:0] & 8'h03;
      end else begin
         path_select_next = path_select_reg;
      end
   end

   // Register update.
   always @(posedge CLOCK) begin
      if (RST) begin
         div0_counts_reg <= `RST_DIV0_COUNTS;
      end else begin
         div0_counts_reg <= div0_counts_next;
      end
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         div0_control_reg <= `RST_DIV0_CONTROL;
      end else begin
         div0_control_reg <= div0_control_next;
      end
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         div0_path_reg <= `RST_DIV0_PATH;
      end else begin
         div0_path_reg <= div0_path_next;
      end
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         div1_counts_reg <= `RST_DIV1_COUNTS;
      end else begin
         div1_counts_reg <= div1_counts_next;
      end
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         div1_control_reg <= `RST_DIV1_CONTROL;
      end else begin
         div1_control_reg <= div1_control_next;
      end
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         path_select_reg <= `RST_PATH_SELECT;
      end else begin
         path_select_reg <= path_select_next;
      end
   end

   // Read byte select.
   always @* begin
      case (idx)
         `IDX_DIV0_COUNTS:  rd_byte = div0_counts_reg;
         `IDX_DIV0_CONTROL: rd_byte = div0_control_reg;
         `IDX_DIV0_PATH:    rd_byte = div0_path_reg;
         `IDX_DIV1_COUNTS:  rd_byte = div1_counts_reg;
         `IDX_DIV1_CONTROL: rd_byte = div1_control_reg;
         `IDX_PATH_SELECT:  rd_byte = path_select_reg;
         default:           rd_byte = 8'h00;
      endcase
   end

   // Read data is taken in the setup cycle, so it stands in the access phase.
   always @* begin
      if (setup_phase) begin
         rdata_next = {24'h000000, rd_byte};
      end else begin
         rdata_next = PRDATA;
      end
   end

   always @(posedge CLOCK) begin
      if (RST) begin
         PRDATA <= 32'h00000000;
      end else begin
         PRDATA <= rdata_next;
      end
   end

   // Chip sync is active low from a pin; an event is its asserting edge.
   sync_2ff u_sync (
      .CLOCK (CLOCK),
      .RST   (RST),
      .d_in  (~SYNC_N),
      .q_out (sync_lvl)
   );

   always @(posedge CLOCK) begin
      if (RST) begin
         sync_d_reg <= 1'b0;
      end else begin
         sync_d_reg <= sync_lvl;
      end
   end

   assign sync_pulse = sync_lvl && !sync_d_reg;

   // Divider settings, one byte per divider.
   assign div_counts  = {div1_counts_reg, div0_counts_reg};
   assign div_control = {div1_control_reg, div0_control_reg};

   // Only the first divider has a correction-disable bit.
   assign div_dcc_disable = {1'b0, div0_path_reg[`BIT_DCC_DISABLE]};

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_div
         chan_divider u_div (
            .CLOCK       (CLOCK),
            .RST         (RST),
            .counts      (div_counts[8*g+7:8*g]),
            .control     (div_control[8*g+7:8*g]),
            .dcc_disable (div_dcc_disable[g]),
            .sync_pulse  (sync_pulse),
            .div_in      (DIV_IN),
            .div_out     (div_out[g])
         );
      end
   endgenerate

   assign div0_out = div_out[0];
   assign DIV1_OUT = div_out[1];

   // Pair source; 01b and 11b keep the divider path.
   assign dir_out = (path_select_reg[1:0] == `SEL_VCO) ? VCO_IN :
                    (path_select_reg[1:0] == `SEL_CLK) ? CLK_IN : div0_out;

   always @* begin
      if (div0_path_reg[`BIT_DIRECT]) begin
         pair_reg = dir_out;
      end else begin
         pair_reg = div0_out;
      end
   end

   // The pair is driven as true and complement.
   assign FIRST_PAIR_POS_OUTPUT = pair_reg;
   assign FIRST_PAIR_NEG_OUTPUT = ~pair_reg;
endmodule // lvpecl_channel_divider

// ---- lvpecl_channel_divider_asserts.sv ----
`timescale 1ns/10ps
module chdiv_checker (
   // Clock and reset.
   input wire        CLOCK,
   input wire        RST,
   // Register bus.
   input wire        PSEL,
   input wire        PENABLE,
   input wire [13:0] PADDR,
   input wire [31:0] PRDATA,
   input wire        PREADY,
   input wire        PSLVERR,
   // Pins.
   input wire        DIV_IN,
   input wire        FIRST_PAIR_POS_OUTPUT,
   input wire        FIRST_PAIR_NEG_OUTPUT,
   input wire        DIV1_OUT
);
   wire [11:0] idx = PADDR[13:2];
   wire        hit = (idx >= 12'h190 && idx <= 12'h194) || idx == 12'h1E1;
   wire        acc = PSEL && PENABLE;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   chk_ready_high: assert property (PSEL |-> PREADY)
      else $error("ready low");
   chk_err_unmapped: assert property (acc && !hit |-> PSLVERR && PRDATA == 0)
      else $error("unmapped access not refused");
   chk_err_mapped: assert property (acc && hit |-> !PSLVERR)
      else $error("mapped access refused");
   chk_err_phase: assert property (PSLVERR |-> acc)
      else $error("error outside access");
   chk_pair_compl: assert property (
      FIRST_PAIR_NEG_OUTPUT != FIRST_PAIR_POS_OUTPUT)
      else $error("pair not complementary");
   chk_div1_reset: assert property (
      $fell(RST) |-> !DIV1_OUT [*8] ##1 !DIV1_OUT [*4] ##1 DIV1_OUT)
      else $error("divider 1 not low for twelve cycles after reset");
   chk_bypass_reset: assert property (
      $fell(RST) |-> (FIRST_PAIR_POS_OUTPUT == DIV_IN) [*4])
      else $error("divider 0 not bypassed");
   chk_bypass_neg: assert property ($fell(RST) |-> FIRST_PAIR_NEG_OUTPUT != DIV_IN)
      else $error("bypass negative leg wrong");
endmodule // chdiv_checker
bind lvpecl_channel_divider chdiv_checker u_chk (.CLOCK(CLOCK), .RST(RST),
   .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .DIV_IN(DIV_IN), .DIV1_OUT(DIV1_OUT),
   .FIRST_PAIR_POS_OUTPUT(FIRST_PAIR_POS_OUTPUT),
   .FIRST_PAIR_NEG_OUTPUT(FIRST_PAIR_NEG_OUTPUT));

// ---- sync_2ff.v ----
`timescale 1ns/10ps
module sync_2ff (
   // Clock and reset.
   input  wire CLOCK,
   input  wire RST,
   // Data.
   input  wire d_in,
   output wire q_out
);
   reg stage1_reg;
   reg stage2_reg;
   always @(posedge CLOCK) begin
      if (RST) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
      end else begin
         stage1_reg <= d_in;
         stage2_reg <= stage1_reg;
      end
   end
   assign q_out = stage2_reg;
endmodule // sync_2ff

// ---- test_lvpecl_channel_divider.sv ----
`timescale 1ns/10ps
module test_lvpecl_channel_divider;
   reg         CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   reg  [13:0] PADDR = 0;
   reg  [31:0] PWDATA = 0, q;
   reg         DIV_IN = 0, VCO_IN = 1, CLK_IN = 0, SYNC_N = 1;
   wire [31:0] PRDATA;
   wire        PREADY, PSLVERR, POS, NEG, D1;
   reg  [45:0] rows [0:6];
   int         n_fail = 0, n_compared = 0;
   int         n = 0;
   always #5 CLOCK = ~CLOCK;
   lvpecl_channel_divider dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DIV_IN(DIV_IN),
      .VCO_IN(VCO_IN), .CLK_IN(CLK_IN), .SYNC_N(SYNC_N), .DIV1_OUT(D1),
      .FIRST_PAIR_POS_OUTPUT(POS), .FIRST_PAIR_NEG_OUTPUT(NEG));
   task chk(input string nm, input [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input w, input [13:0] a, input [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1) @(posedge CLOCK);
      q = PRDATA;
      PSEL <= 0; PENABLE <= 0;
   endtask
   task runs(input s, input int eh, el);
      int h, l;
      h = 0; l = 0;
      @(negedge CLOCK);
      while ((s ? D1 : POS) !== 1'b0) @(negedge CLOCK);
      while ((s ? D1 : POS) !== 1'b1) @(negedge CLOCK);
      while ((s ? D1 : POS) === 1'b1) begin h++; @(negedge CLOCK); end
      while ((s ? D1 : POS) === 1'b0) begin l++; @(negedge CLOCK); end
      chk("high run", h, eh);
      chk("low run", l, el);
      $display("end divide test");
   endtask
   task hold(input string nm, input e);
      repeat (2) begin @(negedge CLOCK); chk(nm, {NEG, POS}, {~e, e}); end
      $display("end %s", nm);
   endtask
   task tally_and_finish;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      rows = '{{14'h640, 32'h00}, {14'h644, 32'h80}, {14'h648, 32'h00},
               {14'h64C, 32'hBB}, {14'h650, 32'h00}, {14'h784, 32'h00},
               {14'h700, 32'h00}};
      repeat (5) @(posedge CLOCK);
      RST <= 0;
      for (int i = 0; i < 7; i++) begin
         apb(0, rows[i][45:32], 0);
         chk("reset read", q, rows[i][31:0]);
      end
      $display("end reset reads");
      runs(1, 12, 12);
      @(posedge CLOCK) DIV_IN <= 1;
      hold("bypass", 1);
      @(posedge CLOCK) DIV_IN <= 0;
      apb(1, 14'h644, 32'hE0);
      hold("bypass over force", 0);
      apb(1, 14'h644, 32'h60);
      hold("force high", 1);
      apb(1, 14'h644, 32'h40);
      hold("force low", 0);
      apb(1, 14'h648, 32'h01);
      apb(1, 14'h640, 32'h21);
      apb(1, 14'h644, 32'h00);
      runs(0, 2, 3);
      apb(1, 14'h648, 32'h03);
      apb(1, 14'h784, 32'h02);
      hold("direct vco", 1);
      apb(1, 14'h784, 32'h00);
      hold("direct clk", 0);
      @(posedge CLOCK) VCO_IN <= 0;
      apb(1, 14'h644, 32'h60);
      apb(1, 14'h784, 32'h01);
      hold("direct none", 1);
      apb(1, 14'h650, 32'h12);
      @(posedge CLOCK) SYNC_N <= 0;
      repeat (3) @(posedge CLOCK);
      @(negedge CLOCK) chk("start high", D1, 1);
      n = 0;
      while (D1 === 1'b1 && n < 40) begin n++; @(negedge CLOCK); end
      chk("phase and high", n, 15);
      @(posedge CLOCK) SYNC_N <= 1;
      $display("end sync test");
      tally_and_finish;
   end
   initial begin
      repeat (3000) @(posedge CLOCK);
      n_fail++;
      tally_and_finish;
   end
endmodule // test_lvpecl_channel_divider
